/* sbr_framer.sv */
// Purpose: periodic-frame crc engine and background diagnostic fragmenter
// Assumes: samples arrive through a 16-word fifo; commands already decoded
// Notes:   the diagnostic response word already holds its own check field
//
// Contract
// [RULE1] crc covers whole frame, msb first
// [RULE2] seed loaded into crc low bits
// [RULE3] seed is zero nibble plus source id
// [RULE4] polynomial x8+x5+x3+x2+x+1 (0x2F)
// [RULE5] eight zeros appended after message
// [RULE6] register after last zero is checksum
// [RULE7] response only for complete valid command
// [RULE8] master collects with broadcast reads
// [RULE9] one fragment per read, same window
// [RULE10] fragments only answer broadcast reads
// [RULE11] four or eight reads per response
// [RULE12] other command aborts pending response
// [RULE13] response data latched before first symbol
// [RULE14] fragment size one gives 4 bits
// [RULE15] periodic mode: read supported, write not
// [RULE16] same encoding and layout as crm
// [RULE17] same check field as crm
// [RULE18] per-source 2-bit keep-alive from zero
// [RULE19] bit-serial crc with done flag
// [RULE20] read counter, idle after last/abort

`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// generic fifo
// ------------------------------------------------------------------
module sbr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    // fill side
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    input  wire logic [WIDTH-1:0] wr_data,
    // drain side
    output logic                  rd_valid,
    input  wire logic             rd_ready,
    output logic      [WIDTH-1:0] rd_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             full_q;
    logic             empty_q;
    logic             wr_fire;
    logic             rd_fire;

    // handshakes and next fill level
    assign wr_fire  = wr_valid & ~full_q;
    assign rd_fire  = rd_ready & ~empty_q;
    assign cnt_d    = cnt_q + {{AW{1'b0}}, wr_fire} - {{AW{1'b0}}, rd_fire};
    assign wr_ready = ~full_q;
    assign rd_valid = ~empty_q;
    assign rd_data  = mem_q[rd_ptr_q];

    // storage needs no reset; only valid entries are ever read
    always_ff @(posedge ref_clk) begin
        if (wr_fire) begin
            mem_q[wr_ptr_q] <= wr_data;
        end
    end

    // flags are registered so they never glitch on the ports
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
            full_q   <= 1'b0;
            empty_q  <= 1'b1;
        end else begin
            wr_ptr_q <= wr_ptr_q + AW'(wr_fire);
            rd_ptr_q <= rd_ptr_q + AW'(rd_fire);
            cnt_q    <= cnt_d;
            full_q   <= (cnt_d == (AW+1)'(DEPTH));
            empty_q  <= (cnt_d == '0);
        end
    end
endmodule

// ------------------------------------------------------------------
// framer top
// ------------------------------------------------------------------
module sbr_framer
    import sbr_pkg::*;
(
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  nrst,
    // mode and configuration
    input  wire logic                  periodic_collection_mode,
    input  wire logic                  kac_enable,
    input  wire logic                  diag_fragment_size,
    // periodic samples in
    input  wire logic                  sample_valid,
    output logic                       sample_ready,
    input  wire sbr_sample_t           sample_data,
    // periodic frames out
    output logic                       frame_valid,
    input  wire logic                  frame_ready,
    output sbr_frame_t                 frame_data,
    // decoded commands
    input  wire logic                  cmd_valid,
    input  wire sbr_cmd_t              cmd_data,
    // response word from the command-response builder
    input  wire logic [SBR_RESP_W-1:0] diag_resp_data,
    // diagnostic fragments out
    output logic                       frag_valid,
    output logic [7:0]                 frag_data,
    output logic                       frag_nibble,
    output logic [3:0]                 frag_window,
    output logic                       diag_pending
);

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------

    // one serial crc step: shift message bit into lsb, fold on carry
    function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic bit_in);
        crc_step = {crc[6:0], bit_in} ^ (crc[7] ? SBR_CRC_POLY : 8'h00); // [RULE4]
    endfunction

    // pick fragment idx of the response, msb first
    function automatic logic [7:0] frag_pick(input logic [31:0] word, input logic [3:0] idx,
                                            input logic nib);
        logic [31:0] sh;
        sh = 32'h0000_0000;
        if (nib) begin
            sh        = word << {idx[2:0], 2'b00};
            frag_pick = {4'h0, sh[31:28]}; // [RULE14]
        end else begin
            sh        = word << {idx[1:0], 3'b000};
            frag_pick = sh[31:24];
        end
    endfunction

    // ----------------------------------------------------------------
    // sample fifo
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CRC_IDLE,
        CRC_SHIFT,
        CRC_DONE
    } sbr_crc_state_t;

    sbr_crc_state_t   crc_st_q;
    sbr_sample_t      fifo_data;
    logic             fifo_valid;
    logic             fifo_pop;
    logic             in_ready;
    logic             sample_ready_q;

    // the crc engine stalls the fifo while a frame is being worked or held
    assign fifo_pop = fifo_valid & (crc_st_q == CRC_IDLE);

    sbr_fifo #(
        .WIDTH ($bits(sbr_sample_t)),
        .DEPTH (SBR_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .wr_valid (sample_valid),
        .wr_ready (in_ready),
        .wr_data  (sample_data),
        .rd_valid (fifo_valid),
        .rd_ready (fifo_pop),
        .rd_data  (fifo_data)
    );

    // ready mirrored one cycle late from the fifo's registered full flag;
    // the fifo still refuses on its own flag, so a write offered on a stale ready is dropped
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sample_ready_q <= 1'b0;
        end else begin
            sample_ready_q <= in_ready;
        end
    end
    assign sample_ready = sample_ready_q;

    // ----------------------------------------------------------------
    // periodic crc engine
    // ----------------------------------------------------------------
    logic [1:0]             kac_q [SBR_SRC_NUM];
    logic [SBR_SHIFT_W-1:0] shift_q;
    logic [SBR_MSG_W-1:0]   msg_q;
    logic [7:0]             crc_q;
    logic [4:0]             bit_cnt_q;
    logic                   frame_valid_q;
    logic [1:0]             kac_field;
    logic [SBR_MSG_W-1:0]   new_msg;
    logic                   last_bit;

    // keep-alive field reads zero when the field is switched off
    assign kac_field = kac_enable ? kac_q[fifo_data.source_slot_id] : SBR_KAC_RST;
    assign new_msg   = {fifo_data.source_slot_id, kac_field, fifo_data.status, fifo_data.data};
    assign last_bit  = (bit_cnt_q == SBR_LAST_BIT);

    // per-source rolling counters
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            for (int i = 0; i < SBR_SRC_NUM; i++) begin
                kac_q[i] <= SBR_KAC_RST; // [RULE18]
            end
        end else if (fifo_pop && kac_enable) begin
            kac_q[fifo_data.source_slot_id] <= kac_q[fifo_data.source_slot_id] + 2'h1; // [RULE18]
        end
    end

    // state and bit counter
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            crc_st_q  <= CRC_IDLE;
            bit_cnt_q <= '0;
        end else begin
            case (crc_st_q)
                CRC_IDLE: begin
                    bit_cnt_q <= '0;
                    if (fifo_pop) begin
                        crc_st_q <= CRC_SHIFT;
                    end
                end
                CRC_SHIFT: begin
                    bit_cnt_q <= bit_cnt_q + 5'h01; // [RULE19]
                    if (last_bit) begin
                        crc_st_q <= CRC_DONE;
                    end
                end
                CRC_DONE: begin
                    if (frame_ready) begin
                        crc_st_q <= CRC_IDLE;
                    end
                end
                default: crc_st_q <= CRC_IDLE;
            endcase
        end
    end

    // shift path: message then eight zeros, one bit per clock
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            shift_q <= '0;
            msg_q   <= '0;
            crc_q   <= 8'h00;
        end else if (fifo_pop) begin
            shift_q <= {new_msg, 8'h00};                      // [RULE5]
            msg_q   <= new_msg;
            crc_q   <= {SBR_SEED_HI, fifo_data.source_slot_id}; // [RULE2] [RULE3]
        end else if (crc_st_q == CRC_SHIFT) begin
            shift_q <= {shift_q[SBR_SHIFT_W-2:0], 1'b0};
            crc_q   <= crc_step(crc_q, shift_q[SBR_SHIFT_W-1]); // [RULE1] [RULE19]
        end
    end

    // frame output held until the transmitter takes it
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            frame_valid_q <= 1'b0;
        end else if (crc_st_q == CRC_SHIFT && last_bit) begin
            frame_valid_q <= 1'b1; // [RULE6] [RULE19]
        end else if (frame_ready) begin
            frame_valid_q <= 1'b0;
        end
    end
    assign frame_valid    = frame_valid_q;
    // one continuous write for the whole struct, so the port has a single driver
    assign frame_data     = {msg_q, crc_q}; // [RULE6]

    // ----------------------------------------------------------------
    // background diagnostic fragmenter
    // ----------------------------------------------------------------
    logic        pend_q;
    logic [3:0]  rd_cnt_q;
    logic [31:0] hold_q;
    logic        size_q;
    logic [3:0]  win_q;
    logic        frag_valid_q;
    logic [7:0]  frag_data_q;
    logic        frag_nib_q;
    logic [3:0]  frag_win_q;
    logic        is_bread;
    logic        is_other;
    logic        prep_ok;
    logic        last_read;
    logic [31:0] resp_word;
    logic [3:0]  reads_need;

    // command classification
    assign is_bread   = cmd_valid & cmd_data.bcast_read;
    assign is_other   = cmd_valid & ~cmd_data.bcast_read;
    assign prep_ok    = is_other & cmd_data.complete & cmd_data.crm_valid
                        & periodic_collection_mode & cmd_data.is_read; // [RULE7] [RULE15]
    assign reads_need = size_q ? SBR_READS_NIB : SBR_READS_BYTE;      // [RULE11]
    assign last_read  = (rd_cnt_q == reads_need - 4'h1);
    // first read takes the live word, later reads the latched copy
    assign resp_word  = (rd_cnt_q == 4'h0) ? diag_resp_data : hold_q;

    // pending state, read counter and latched response
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pend_q   <= 1'b0;
            rd_cnt_q <= 4'h0;
            hold_q   <= '0;
            size_q   <= 1'b0;
            win_q    <= 4'h0;
        end else if (is_other) begin
            // a new command ends any response; a valid read opens a fresh one
            pend_q   <= prep_ok;            // [RULE12] [RULE20]
            rd_cnt_q <= 4'h0;
            size_q   <= diag_fragment_size;
            win_q    <= cmd_data.window;
        end else if (is_bread && pend_q) begin
            if (rd_cnt_q == 4'h0) begin
                hold_q <= diag_resp_data;   // [RULE13]
            end
            rd_cnt_q <= last_read ? 4'h0 : rd_cnt_q + 4'h1; // [RULE20]
            pend_q   <= ~last_read;          // [RULE11] [RULE20]
        end
    end

    // one fragment per broadcast read while a response is pending
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            frag_valid_q <= 1'b0;
            frag_data_q  <= 8'h00;
            frag_nib_q   <= 1'b0;
            frag_win_q   <= 4'h0;
        end else begin
            frag_valid_q <= is_bread & pend_q; // [RULE9] [RULE10]
            if (is_bread && pend_q) begin
                // word passes unchanged: layout and check field as built upstream
                frag_data_q <= frag_pick(resp_word, rd_cnt_q, size_q); // [RULE9] [RULE16] [RULE17]
                frag_nib_q  <= size_q;  // [RULE14]
                frag_win_q  <= win_q;   // [RULE9]
            end
        end
    end

    assign frag_valid   = frag_valid_q;
    assign frag_data    = frag_data_q;
    assign frag_nibble  = frag_nib_q;
    assign frag_window  = frag_win_q;
    assign diag_pending = pend_q;

endmodule

`default_nettype wire

/* sbr_framer_asserts.sv */
// Purpose: port-level checks on the framer
// Assumes: one clock, synchronous active-low reset
// Notes:   crc is rebuilt here so every frame is judged
`timescale 1ns/10ps
`default_nettype none
module sbr_framer_asserts
    import sbr_pkg::*;
(
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       nrst,
    // watched ports
    input wire logic       periodic_collection_mode,
    input wire logic       frame_valid,
    input wire logic       frame_ready,
    input wire sbr_frame_t frame_data,
    input wire logic       cmd_valid,
    input wire sbr_cmd_t   cmd_data,
    input wire logic       frag_valid,
    input wire logic [7:0] frag_data,
    input wire logic       frag_nibble,
    input wire logic [3:0] frag_window,
    input wire logic       diag_pending
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic [3:0] win_q;
    logic [3:0] nfr_q;
    // command decode shared by the properties
    wire rd = cmd_valid && cmd_data.bcast_read;
    wire nb = cmd_valid && !cmd_data.bcast_read;
    wire ok = nb && cmd_data.complete && cmd_data.crm_valid && cmd_data.is_read && periodic_collection_mode;
    wire [3:0] lim = frag_nibble ? SBR_READS_NIB : SBR_READS_BYTE;
    // window and fragment count of the open response
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            win_q <= 4'h0;
            nfr_q <= 4'h0;
        end else if (nb) begin
            win_q <= cmd_data.window;
            nfr_q <= 4'h0;
        end else if (frag_valid) begin
            nfr_q <= nfr_q + 4'h1;
        end
    end
    // serial reference: seed, message, eight zeros
    function automatic logic [7:0] crc_of(input logic [19:0] m);
        logic [7:0]  c;
        logic [27:0] x;
        logic        fb;
        c = {SBR_SEED_HI, m[19:16]};
        x = {m, 8'h00};
        for (int i = 27; i >= 0; i--) begin
            fb = c[7];
            c = {c[6:0], x[i]} ^ (fb ? SBR_CRC_POLY : 8'h00);
        end
        return c;
    endfunction
    property p_frag_cause; frag_valid |-> $past(rd && diag_pending); endproperty
    a_frag_cause: assert property (p_frag_cause) else $error("fragment without read");
    property p_frag_answer; rd && diag_pending |=> frag_valid; endproperty
    a_frag_answer: assert property (p_frag_answer) else $error("read not answered");
    property p_frag_window; frag_valid |-> frag_window == win_q; endproperty
    a_frag_window: assert property (p_frag_window) else $error("wrong window");
    property p_nib_zero; frag_valid && frag_nibble |-> frag_data[7:4] == 4'h0; endproperty
    a_nib_zero: assert property (p_nib_zero) else $error("nibble upper bits set");
    property p_frag_count; frag_valid |-> nfr_q < lim; endproperty
    a_frag_count: assert property (p_frag_count) else $error("too many fragments");
    property p_last_idle; frag_valid && nfr_q == lim - 4'h1 |-> !diag_pending; endproperty
    a_last_idle: assert property (p_last_idle) else $error("pending after last");
    property p_abort; nb |=> !frag_valid && diag_pending == $past(ok); endproperty
    a_abort: assert property (p_abort) else $error("command outcome wrong");
    property p_open; $rose(diag_pending) |-> $past(ok); endproperty
    a_open: assert property (p_open) else $error("response opened wrongly");
    property p_frame_hold; frame_valid && !frame_ready |=> frame_valid && $stable(frame_data); endproperty
    a_frame_hold: assert property (p_frame_hold) else $error("frame dropped");
    property p_frame_crc; frame_valid |-> frame_data.crc == crc_of(frame_data.msg); endproperty
    a_frame_crc: assert property (p_frame_crc) else $error("bad crc");
    c_frame: cover property (frame_valid && frame_ready);
    c_last: cover property (frag_valid && frag_nibble && nfr_q == 4'h7);
    c_abort: cover property (diag_pending && nb && !ok);
endmodule
bind sbr_framer sbr_framer_asserts i_chk (
    .ref_clk(ref_clk), .nrst(nrst), .periodic_collection_mode(periodic_collection_mode),
    .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_data(frame_data),
    .cmd_valid(cmd_valid), .cmd_data(cmd_data), .frag_valid(frag_valid), .frag_data(frag_data),
    .frag_nibble(frag_nibble), .frag_window(frag_window), .diag_pending(diag_pending)
);
`default_nettype wire

/* sbr_master_model.sv */
// Purpose: bus master stand-in: frame sink and command source
// Assumes: commands one cycle each, idle data scrambled
// Notes:   stall_mode 0 prompt, 1 random stalls, 2 blocked
`timescale 1ns/10ps
`default_nettype none
module sbr_master_model
    import sbr_pkg::*;
(
    // clock
    input wire logic       ref_clk,
    // frame sink
    input wire logic [1:0] stall_mode,
    output var logic       frame_ready,
    // command source
    output var logic       cmd_valid,
    output var sbr_cmd_t   cmd_data
);
    integer seed = 32'h24e8;
    initial begin
        frame_ready = 1'b0;
        cmd_valid = 1'b0;
        cmd_data = 8'h00;
    end
    // sink readiness; a real master may stall for long stretches
    always @(posedge ref_clk) begin
        #1;
        frame_ready = (stall_mode == 2'h0) || (stall_mode == 2'h1 && ($random(seed) & 1) == 1);
    end
    // one command pulse; released data is inverted so stale values never pass
    task send(input sbr_cmd_t c);
        @(posedge ref_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_data = c;
        @(posedge ref_clk);
        #1;
        cmd_valid = 1'b0;
        cmd_data = ~c;
    endtask
    // broadcast reads drain the open response
    task collect(input int n);
        repeat (n) send(8'h80);
    endtask
endmodule
`default_nettype wire

/* sbr_pkg.sv */
// Purpose: shared constants and carriers for the sensor bus response framer
// Assumes: one 40 MHz clock, synchronous active-low reset
// Notes:   frame layout is source id, keep-alive, status, sensor data, crc

package sbr_pkg;

    // ----------------------------------------------------------------
    // periodic frame layout
    // ----------------------------------------------------------------
    localparam int          SBR_SRC_W      = 4;
    localparam int          SBR_KAC_W      = 2;
    localparam int          SBR_STAT_W     = 4;
    localparam int          SBR_DATA_W     = 10;
    localparam int          SBR_MSG_W      = 20;
    localparam int          SBR_CRC_W      = 8;
    localparam int          SBR_SHIFT_W    = 28;
    localparam int          SBR_SRC_NUM    = 16;
    localparam logic [7:0]  SBR_CRC_POLY   = 8'h2F;
    localparam logic [3:0]  SBR_SEED_HI    = 4'h0;
    localparam logic [1:0]  SBR_KAC_RST    = 2'h0;
    localparam logic [4:0]  SBR_LAST_BIT   = 5'h1B;

    // ----------------------------------------------------------------
    // background diagnostic response
    // ----------------------------------------------------------------
    localparam int          SBR_RESP_W     = 32;
    localparam logic [3:0]  SBR_READS_BYTE = 4'h4;
    localparam logic [3:0]  SBR_READS_NIB  = 4'h8;
    localparam int          SBR_FIFO_DEPTH = 16;

    // one periodic sample waiting to be framed
    typedef struct packed {
        logic [SBR_SRC_W-1:0]  source_slot_id;
        logic [SBR_STAT_W-1:0] status;
        logic [SBR_DATA_W-1:0] data;
    } sbr_sample_t;

    // framed periodic response: message then checksum
    typedef struct packed {
        logic [SBR_MSG_W-1:0] msg;
        logic [SBR_CRC_W-1:0] crc;
    } sbr_frame_t;

    // one decoded command from the receiver
    typedef struct packed {
        logic       bcast_read;
        logic       complete;
        logic       crm_valid;
        logic       is_read;
        logic [3:0] window;
    } sbr_cmd_t;

endpackage

/* tb_top.sv */
// Purpose: self-checking bench for the framer
// Assumes: 40 MHz clock, inputs driven 1 ns after the edge
// Notes:   drivers queue expectations, one monitor compares
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import sbr_pkg::*;
;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic pcm = 1'b1;
    logic kac_enable = 1'b0;
    logic dfs = 1'b0;
    logic sample_valid = 1'b0;
    logic sample_ready;
    sbr_sample_t sample_data = 18'h00000;
    logic frame_valid;
    logic frame_ready;
    sbr_frame_t frame_data;
    logic cmd_valid;
    sbr_cmd_t cmd_data;
    logic [31:0] diag_resp_data = 32'h00000000;
    logic frag_valid;
    logic [7:0] frag_data;
    logic frag_nibble;
    logic [3:0] frag_window;
    logic diag_pending;
    logic [1:0] stall_mode = 2'h0;
    logic [1:0] kac [16];
    sbr_frame_t fq [$];
    logic [12:0] gq [$];
    integer seed = 32'h24e8;
    int n_mismatch = 0;
    int checked = 0;
    int acc;
    always #12.5 ref_clk = ~ref_clk;
    sbr_framer i_dut (.ref_clk(ref_clk), .nrst(nrst), .periodic_collection_mode(pcm), .kac_enable(kac_enable),
        .diag_fragment_size(dfs), .sample_valid(sample_valid), .sample_ready(sample_ready),
        .sample_data(sample_data), .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_data(frame_data),
        .cmd_valid(cmd_valid), .cmd_data(cmd_data), .diag_resp_data(diag_resp_data), .frag_valid(frag_valid),
        .frag_data(frag_data), .frag_nibble(frag_nibble), .frag_window(frag_window), .diag_pending(diag_pending));
    sbr_master_model i_master (.ref_clk(ref_clk), .stall_mode(stall_mode), .frame_ready(frame_ready),
        .cmd_valid(cmd_valid), .cmd_data(cmd_data));
    task report(input string what, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (e !== g) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task cmp_frame(input sbr_frame_t e, input sbr_frame_t g);
        report("frame", {4'h0, e}, {4'h0, g});
    endtask
    task cmp_frag(input logic [12:0] e, input logic [12:0] g);
        report("fragment", {19'h0, e}, {19'h0, g});
    endtask
    task cmp_flag(input string what, input logic e, input logic g);
        report(what, {31'h0, e}, {31'h0, g});
    endtask
    task print_verdict;
        if (n_mismatch == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // augmented serial crc: seed, message msb first, eight zeros
    function automatic logic [7:0] crc_ref(input logic [19:0] m);
        logic [7:0]  c;
        logic [27:0] x;
        c = {4'h0, m[19:16]};
        x = {m, 8'h00};
        for (int i = 27; i >= 0; i--)
            c = {c[6:0], x[i]} ^ (c[7] ? 8'h2F : 8'h00);
        return c;
    endfunction
    // monitor: every result takes the oldest note
    always @(posedge ref_clk) begin
        if (frame_valid === 1'b1 && frame_ready === 1'b1) begin
            if (fq.size() == 0) cmp_flag("extra_frame", 1'b0, 1'b1);
            else cmp_frame(fq.pop_front(), frame_data);
        end
        if (frag_valid === 1'b1) begin
            if (gq.size() == 0) cmp_flag("extra_fragment", 1'b0, 1'b1);
            else cmp_frag(gq.pop_front(), {frag_nibble, frag_window, frag_data});
        end
    end
    // offers on every other edge so the late ready never admits a lost write
    task run_batch(input int n, input logic ken, input logic [1:0] mode, output int a);
        sbr_sample_t s;
        logic [19:0] m;
        kac_enable = ken;
        stall_mode = mode;
        a = 0;
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            #1;
            if (sample_ready === 1'b1) begin
                s = 18'($random(seed));
                m = {s.source_slot_id, ken ? kac[s.source_slot_id] : 2'h0, s.status, s.data};
                fq.push_back({m, crc_ref(m)});
                if (ken) kac[s.source_slot_id]++;
                sample_data = s;
                sample_valid = 1'b1;
                a++;
                @(posedge ref_clk);
                #1;
                sample_valid = 1'b0;
                sample_data = ~s;
            end
        end
    endtask
    task drain;
        for (int i = 0; i < 6000 && fq.size() > 0; i++) @(posedge ref_clk);
        #1;
        cmp_flag("drained", 1'b1, fq.size() == 0);
    endtask
    // open a response and issue n reads; the word moves after the first read
    task diag(input logic sz, input logic [3:0] win, input int n);
        logic [31:0] w;
        int lim;
        w = $random(seed);
        lim = sz ? 8 : 4;
        dfs = sz;
        diag_resp_data = w;
        i_master.send({1'b0, 1'b1, 1'b1, 1'b1, win});
        for (int k = 0; k < n; k++) begin
            if (k < lim) gq.push_back(sz ? {1'b1, win, 4'h0, w[31-4*k -: 4]} : {1'b0, win, w[31-8*k -: 8]});
            i_master.collect(1);
            diag_resp_data = $random(seed);
        end
        @(posedge ref_clk);
        #1;
        cmp_flag("pending", n < lim, diag_pending);
    endtask
    initial begin
        foreach (kac[i]) kac[i] = 2'h0;
        repeat (2) @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        run_batch(40, 1'b1, 2'h2, acc);
        cmp_flag("fifo_refused", 1'b1, acc >= 16 && acc <= 18);
        stall_mode = 2'h1;
        drain;
        run_batch(6, 1'b0, 2'h0, acc);
        drain;
        run_batch(10, 1'b1, 2'h1, acc);
        drain;
        diag(1'b0, 4'h5, 5);
        diag(1'b1, 4'hA, 8);
        // each refused command also cuts a response that is open
        for (int v = 0; v < 4; v++) begin
            pcm = 1'b1;
            diag(1'b0, 4'h9, 1);
            pcm = (v != 3);
            i_master.send({1'b0, v != 0, v != 1, v != 2, 4'h6});
            i_master.collect(1);
            cmp_flag("pending_cut", 1'b0, diag_pending);
        end
        print_verdict;
    end
    initial begin
        #(25 * 20000);
        n_mismatch++;
        print_verdict;
    end
endmodule
`default_nettype wire
